//--- tpsi_cfg.svh
/*
 * Constants of the trace port signal interface: register offsets, field
 * positions, reset values and output encodings.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef TPSI_CFG_SVH
`define TPSI_CFG_SVH

`define TPSI_ADDR_W 12
`define TPSI_OFF_CTRL 12'h000
`define TPSI_OFF_PROCID 12'h004
`define TPSI_OFF_WP_ADDR 12'h008
`define TPSI_OFF_WP_MASK 12'h00C
`define TPSI_OFF_STATUS 12'h010
`define TPSI_OFF_MATCH_CNT 12'h014

`define TPSI_CTRL_BIG_END 0
`define TPSI_CTRL_HIGH_VEC 1
`define TPSI_CTRL_WP_RW 2
`define TPSI_CTRL_WP_RW_CARE 3
`define TPSI_CTRL_W 4

`define TPSI_STAT_ENABLE 0
`define TPSI_STAT_ABORTED 1
`define TPSI_STAT_DEBUG 2
`define TPSI_STAT_MATCH 3

`define TPSI_CTRL_RST 4'h0
`define TPSI_PROCID_RST 32'h0000_0000
`define TPSI_WP_ADDR_RST 32'h0000_0000
`define TPSI_WP_MASK_RST 32'hFFFF_FFFF

`define TPSI_HS_ABSENT 2'h2
`define TPSI_HS_WAIT 2'h0
`define TPSI_HS_GO 2'h1
`define TPSI_HS_LAST 2'h3

`define TPSI_SIZE_BYTE 2'h0
`define TPSI_SIZE_HALF 2'h1
`define TPSI_SIZE_WORD 2'h2
`define TPSI_SIZE_RSVD 2'h3

`endif

//--- tpsi_pkg.sv
/*
 * Types of the trace port signal interface: core input bundle, trace
 * output bundle and module state records.
 * Assumes tpsi_cfg.svh is on the include path.
 */
`default_nettype none
`include "tpsi_cfg.svh"

package tpsi_pkg;

	typedef struct packed {
		logic [1:0] hs_decode;
		logic [1:0] hs_execute;
		logic [31:0] daddr;
		logic [1:0] dsize;
		logic multi_xfer;
		logic dreq;
		logic dwrite;
		logic [31:0] iaddr;
		logic iabort;
		logic ifetch;
		logic iseq;
		logic compressed;
		logic cop_first;
		logic data_abort;
		logic stalled;
		logic cop_pass;
		logic in_debug;
		logic executed;
	} tpsi_core_t;

	typedef struct packed {
		logic [1:0] cop_handshake_decode;
		logic [1:0] cop_handshake_execute;
		logic [31:0] data_trace_address;
		logic [1:0] data_transfer_size;
		logic data_more_early_seq;
		logic data_sequential;
		logic data_mem_request;
		logic data_write_flag;
		logic high_vector_select;
		logic [30:0] instr_fetch_address;
		logic instr_abort_flag;
		logic [7:0] id_code_upper_byte;
		logic [7:0] id_code_second_byte;
		logic instr_request_n;
		logic instr_executed;
		logic fetch_sequential;
		logic compressed_state_flag;
		logic cop_late_cancel;
		logic core_stall_n;
		logic cop_pass;
		logic watchpoint_match;
		logic trace_big_endian;
		logic debug_state_ack;
		logic [31:0] process_identifier;
		logic process_id_write_strobe;
	} tpsi_trace_t;

	typedef enum logic [1:0] {
		TPSI_LC_RUN = 2'b01,
		TPSI_LC_ABORTED = 2'b10
	} tpsi_lc_state_t;

	typedef struct packed {
		logic [31:0] value;
		logic strobe;
	} tpsi_procid_t;

	typedef struct packed {
		tpsi_lc_state_t lc;
		logic [`TPSI_CTRL_W-1:0] ctrl;
		logic [31:0] wp_addr;
		logic [31:0] wp_mask;
		logic [15:0] match_cnt;
		logic [31:0] rdata;
		logic err;
		logic [31:0] id_s1;
		logic [31:0] id_s2;
		logic dmore_prev;
	} tpsi_main_t;

endpackage

`default_nettype wire

//--- tpsi_port.sv
/*
 * Trace port signal interface: gathers core pipeline, fetch, data,
 * coprocessor and debug indications into one trace bundle, adds the
 * watchpoint comparator, late-cancel tracking and identification mirror,
 * and drives it out through one register stage while the trace unit
 * enables the port. Software reaches the configuration over APB.
 * Assumes core_i and trace_port_enable_i come from core-clock logic;
 * scan_id_code_i is a strap from outside and is synchronised here.
 */
`default_nettype none
`include "tpsi_cfg.svh"

module tpsi_port import tpsi_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic apb_psel_i,
	input wire logic apb_penable_i,
	input wire logic apb_pwrite_i,
	input wire logic [`TPSI_ADDR_W-1:0] apb_paddr_i,
	input wire logic [31:0] apb_pwdata_i,
	output logic [31:0] apb_prdata_o,
	output logic apb_pready_o,
	output logic apb_pslverr_o,
	input wire tpsi_core_t core_i,
	input wire logic [31:0] scan_id_code_i,
	input wire logic trace_port_enable_i,
	output logic [1:0] cop_handshake_decode_o,
	output logic [1:0] cop_handshake_execute_o,
	output logic [31:0] data_trace_address_o,
	output logic [1:0] data_transfer_size_o,
	output logic data_more_early_seq_o,
	output logic data_sequential_o,
	output logic data_mem_request_o,
	output logic data_write_flag_o,
	output logic high_vector_select_o,
	output logic [30:0] instr_fetch_address_o,
	output logic instr_abort_flag_o,
	output logic [7:0] id_code_upper_byte_o,
	output logic [7:0] id_code_second_byte_o,
	output logic instr_request_n_o,
	output logic instr_executed_o,
	output logic fetch_sequential_o,
	output logic compressed_state_flag_o,
	output logic cop_late_cancel_o,
	output logic core_stall_n_o,
	output logic cop_pass_o,
	output logic watchpoint_match_o,
	output logic trace_big_endian_o,
	output logic debug_state_ack_o,
	output logic [31:0] process_identifier_o,
	output logic process_id_write_strobe_o
);

	// register index decode, shared by read and write paths
	function automatic logic [2:0] reg_decode(input logic [`TPSI_ADDR_W-1:0] addr);
		logic [2:0] idx;
		idx = 3'h7;
		case (addr)
			`TPSI_OFF_CTRL: begin
				idx = 3'h0;
			end
			`TPSI_OFF_PROCID: begin
				idx = 3'h1;
			end
			`TPSI_OFF_WP_ADDR: begin
				idx = 3'h2;
			end
			`TPSI_OFF_WP_MASK: begin
				idx = 3'h3;
			end
			`TPSI_OFF_STATUS: begin
				idx = 3'h4;
			end
			`TPSI_OFF_MATCH_CNT: begin
				idx = 3'h5;
			end
			default: begin
				idx = 3'h7;
			end
		endcase
		return idx;
	endfunction

	// mask bit set means that address bit is ignored
	function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b, input logic [31:0] mask);
		logic [31:0] diff;
		diff = (a ^ b) & ~mask;
		return (diff == 32'h0000_0000);
	endfunction

	// read word for a decoded index; unmapped reads give zero
	function automatic logic [31:0] reg_read(input logic [2:0] idx, input tpsi_main_t st,
		input logic [31:0] procid, input logic [31:0] status);
		logic [31:0] word;
		word = 32'h0000_0000;
		case (idx)
			3'h0: begin
				word = {28'h000_0000, st.ctrl};
			end
			3'h1: begin
				word = procid;
			end
			3'h2: begin
				word = st.wp_addr;
			end
			3'h3: begin
				word = st.wp_mask;
			end
			3'h4: begin
				word = status;
			end
			3'h5: begin
				word = {16'h0000, st.match_cnt};
			end
			default: begin
				word = 32'h0000_0000;
			end
		endcase
		return word;
	endfunction

	// late-cancel tracking: set on a data abort, cleared by a clean access or a coprocessor first cycle
	function automatic tpsi_lc_state_t lc_next(input tpsi_lc_state_t cur, input logic set, input logic clear);
		tpsi_lc_state_t nxt;
		nxt = cur;
		case (cur)
			TPSI_LC_RUN: begin
				if (set) begin
					nxt = TPSI_LC_ABORTED;
				end
			end
			TPSI_LC_ABORTED: begin
				// a new abort wins over a clear in the same cycle
				if (clear && !set) begin
					nxt = TPSI_LC_RUN;
				end
			end
			default: begin
				nxt = TPSI_LC_RUN;
			end
		endcase
		return nxt;
	endfunction

	tpsi_main_t s_d;
	tpsi_main_t s_q;
	tpsi_trace_t trace_pre;
	tpsi_trace_t trace_out;
	logic [31:0] procid_value;
	logic procid_strobe;
	logic setup_phase;
	logic access_phase;
	logic [2:0] rd_idx;
	logic [2:0] wr_idx;
	logic procid_wr;
	logic wp_hit;
	logic lc_active;
	logic early_seq;
	logic [31:0] status_word;
	logic wr_access;
	logic wp_addr_hit;
	logic wp_rw_hit;
	logic lc_set;
	logic lc_clear;

	assign setup_phase = apb_psel_i & ~apb_penable_i;
	assign access_phase = apb_psel_i & apb_penable_i;
	assign rd_idx = reg_decode(apb_paddr_i);
	assign wr_idx = reg_decode(apb_paddr_i);
	assign wr_access = access_phase & apb_pwrite_i;
	assign procid_wr = wr_access & (wr_idx == 3'h1);

	// comparator runs on its own; no enable bit gates it
	always_comb begin
		wp_addr_hit = masked_eq(core_i.daddr, s_q.wp_addr, s_q.wp_mask);
		wp_rw_hit = !s_q.ctrl[`TPSI_CTRL_WP_RW_CARE]
			|| (core_i.dwrite == s_q.ctrl[`TPSI_CTRL_WP_RW]);
		wp_hit = core_i.dreq && wp_addr_hit && wp_rw_hit;
	end

	// cancel only in a coprocessor first cycle after a data abort
	assign lc_active = (s_q.lc == TPSI_LC_ABORTED) && core_i.cop_first;

	// a fresh abort outranks a clearing access in the same cycle
	assign lc_set = core_i.dreq && core_i.data_abort;
	assign lc_clear = core_i.cop_first || core_i.dreq;

	// early indication only inside multiples, only with request low
	assign early_seq = core_i.multi_xfer && !core_i.dreq;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`TPSI_STAT_ENABLE] = trace_port_enable_i;
		status_word[`TPSI_STAT_ABORTED] = (s_q.lc == TPSI_LC_ABORTED);
		status_word[`TPSI_STAT_DEBUG] = core_i.in_debug;
		status_word[`TPSI_STAT_MATCH] = wp_hit;
	end

	always_comb begin
		trace_pre = '0;
		trace_pre.cop_handshake_decode = core_i.hs_decode;
		trace_pre.cop_handshake_execute = core_i.hs_execute;

		// data access side
		trace_pre.data_trace_address = core_i.daddr;
		trace_pre.data_transfer_size = core_i.dsize;
		trace_pre.data_more_early_seq = early_seq;
		// sequential flag follows the early indication one cycle later
		trace_pre.data_sequential = s_q.dmore_prev;
		trace_pre.data_mem_request = core_i.dreq;
		trace_pre.data_write_flag = core_i.dwrite;
		trace_pre.high_vector_select = s_q.ctrl[`TPSI_CTRL_HIGH_VEC];

		// instruction fetch side
		trace_pre.instr_fetch_address = core_i.iaddr[31:1];
		trace_pre.instr_abort_flag = core_i.iabort;
		trace_pre.id_code_upper_byte = s_q.id_s2[31:24];
		trace_pre.id_code_second_byte = s_q.id_s2[15:8];
		trace_pre.instr_request_n = ~core_i.ifetch;
		trace_pre.instr_executed = core_i.executed;
		trace_pre.fetch_sequential = core_i.iseq;
		trace_pre.compressed_state_flag = core_i.compressed;

		// coprocessor, watchpoint and debug side
		trace_pre.cop_late_cancel = lc_active;
		trace_pre.core_stall_n = ~core_i.stalled;
		trace_pre.cop_pass = core_i.cop_pass;
		trace_pre.watchpoint_match = wp_hit;
		trace_pre.trace_big_endian = s_q.ctrl[`TPSI_CTRL_BIG_END];
		trace_pre.debug_state_ack = core_i.in_debug;
		trace_pre.process_identifier = procid_value;
		trace_pre.process_id_write_strobe = procid_strobe;
	end

	always_comb begin
		s_d = s_q;
		// strap passes two flops before anything reads it
		s_d.id_s1 = scan_id_code_i;
		s_d.id_s2 = s_q.id_s1;
		s_d.dmore_prev = early_seq;
		if (wp_hit) begin
			s_d.match_cnt = s_q.match_cnt + 16'h0001;
		end

		s_d.lc = lc_next(s_q.lc, lc_set, lc_clear);

		// read data and error are captured in the setup cycle
		if (setup_phase) begin
			s_d.err = (rd_idx == 3'h7);
			s_d.rdata = reg_read(rd_idx, s_q, procid_value, status_word);
		end

		if (wr_access) begin
			case (wr_idx)
				3'h0: begin
					s_d.ctrl = apb_pwdata_i[`TPSI_CTRL_W-1:0];
				end
				3'h2: begin
					s_d.wp_addr = apb_pwdata_i;
				end
				3'h3: begin
					s_d.wp_mask = apb_pwdata_i;
				end
				3'h1: begin
					// value lands in the holder instance
				end
				3'h4, 3'h5: begin
					// read-only words ignore writes
				end
				default: begin
					// unmapped writes are dropped
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_q.lc <= TPSI_LC_RUN;
			s_q.ctrl <= `TPSI_CTRL_RST;
			s_q.wp_addr <= `TPSI_WP_ADDR_RST;
			s_q.wp_mask <= `TPSI_WP_MASK_RST;
			s_q.match_cnt <= 16'h0000;
			s_q.rdata <= 32'h0000_0000;
			s_q.err <= 1'b0;
			s_q.id_s1 <= 32'h0000_0000;
			s_q.id_s2 <= 32'h0000_0000;
			s_q.dmore_prev <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	tpsi_procid u_procid (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.wr_i(procid_wr),
		.data_i(apb_pwdata_i),
		.value_o(procid_value),
		.strobe_o(procid_strobe)
	);

	tpsi_stage u_stage (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.enable_i(trace_port_enable_i),
		.trace_i(trace_pre),
		.trace_o(trace_out)
	);

	// zero wait states: ready in every access cycle
	assign apb_pready_o = access_phase;
	assign apb_prdata_o = s_q.rdata;
	assign apb_pslverr_o = access_phase & s_q.err;

	// stage outputs fan out to the pins
	assign cop_handshake_decode_o = trace_out.cop_handshake_decode;
	assign cop_handshake_execute_o = trace_out.cop_handshake_execute;
	assign data_trace_address_o = trace_out.data_trace_address;
	assign data_transfer_size_o = trace_out.data_transfer_size;
	assign data_more_early_seq_o = trace_out.data_more_early_seq;
	assign data_sequential_o = trace_out.data_sequential;
	assign data_mem_request_o = trace_out.data_mem_request;
	assign data_write_flag_o = trace_out.data_write_flag;
	assign high_vector_select_o = trace_out.high_vector_select;
	assign instr_fetch_address_o = trace_out.instr_fetch_address;
	assign instr_abort_flag_o = trace_out.instr_abort_flag;
	assign id_code_upper_byte_o = trace_out.id_code_upper_byte;
	assign id_code_second_byte_o = trace_out.id_code_second_byte;
	assign instr_request_n_o = trace_out.instr_request_n;
	assign instr_executed_o = trace_out.instr_executed;
	assign fetch_sequential_o = trace_out.fetch_sequential;
	assign compressed_state_flag_o = trace_out.compressed_state_flag;
	assign cop_late_cancel_o = trace_out.cop_late_cancel;
	assign core_stall_n_o = trace_out.core_stall_n;
	assign cop_pass_o = trace_out.cop_pass;
	assign watchpoint_match_o = trace_out.watchpoint_match;
	assign trace_big_endian_o = trace_out.trace_big_endian;
	assign debug_state_ack_o = trace_out.debug_state_ack;
	assign process_identifier_o = trace_out.process_identifier;
	assign process_id_write_strobe_o = trace_out.process_id_write_strobe;

endmodule

`default_nettype wire

//--- tpsi_port_asserts.sv
/*
 * checker for the trace port: stage timing, idle levels and strobe shape.
 * assumes it is bound into tpsi_port and that all ports share clk_i.
 */
`default_nettype none

module tpsi_port_asserts import tpsi_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic apb_psel_i,
	input wire logic apb_penable_i,
	input wire logic apb_pready_o,
	input wire tpsi_core_t core_i,
	input wire logic trace_port_enable_i,
	input wire logic [1:0] cop_handshake_decode_o,
	input wire logic [1:0] cop_handshake_execute_o,
	input wire logic [30:0] instr_fetch_address_o,
	input wire logic data_more_early_seq_o,
	input wire logic data_sequential_o,
	input wire logic data_mem_request_o,
	input wire logic instr_request_n_o,
	input wire logic core_stall_n_o,
	input wire logic process_id_write_strobe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_idle_when_off: assert property (
		!trace_port_enable_i |=> cop_handshake_decode_o == 2'h2 && !data_mem_request_o && instr_request_n_o
		&& core_stall_n_o) else $error("trace outputs not idle while disabled");
	a_hs_codes: assert property (
		trace_port_enable_i |=> cop_handshake_decode_o == $past(core_i.hs_decode)
		&& cop_handshake_execute_o == $past(core_i.hs_execute)) else $error("handshake code mismatch");
	a_req_copy: assert property (
		trace_port_enable_i |=> data_mem_request_o == $past(core_i.dreq)) else $error("data request mismatch");
	a_fetch_addr: assert property (
		trace_port_enable_i |=> instr_fetch_address_o == 31'($past(core_i.iaddr) >> 1))
		else $error("fetch address mismatch");
	a_early_seq: assert property (
		trace_port_enable_i |=> data_more_early_seq_o == ($past(core_i.multi_xfer) && !$past(core_i.dreq)))
		else $error("early sequential mismatch");
	a_seq_lag: assert property (
		trace_port_enable_i && $past(trace_port_enable_i) |=> data_sequential_o == $past(data_more_early_seq_o))
		else $error("sequential data not one cycle behind early flag");
	a_stall_low: assert property (
		trace_port_enable_i |=> core_stall_n_o != $past(core_i.stalled)) else $error("stall output mismatch");
	a_fetch_req: assert property (
		trace_port_enable_i |=> instr_request_n_o != $past(core_i.ifetch)) else $error("fetch request mismatch");
	a_strobe_pulse: assert property (
		$rose(process_id_write_strobe_o) |=> !process_id_write_strobe_o) else $error("strobe longer than one cycle");
	a_apb_ready: assert property (
		apb_psel_i && apb_penable_i |-> apb_pready_o) else $error("ready missing in access cycle");
endmodule

bind tpsi_port tpsi_port_asserts chk_u (.clk_i, .reset_i, .apb_psel_i, .apb_penable_i, .apb_pready_o, .core_i,
	.trace_port_enable_i, .cop_handshake_decode_o, .cop_handshake_execute_o, .instr_fetch_address_o,
	.data_more_early_seq_o, .data_sequential_o, .data_mem_request_o, .instr_request_n_o, .core_stall_n_o,
	.process_id_write_strobe_o);

`default_nettype wire

//--- tpsi_port_tb_top.sv
/*
 * testbench for the trace port: row table of core states and identification mirror,
 * then registers, process id, watchpoint, late cancel and disable.
 * assumes tpsi_port, tpsi_trace_unit and the bound checker are compiled.
 */
`default_nettype none

module tpsi_port_tb_top import tpsi_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [1:0] hd, he, sz; logic multi, dreq, fetch, stall, early, reqn, stn;} tpsi_row_t;
	localparam tpsi_row_t ROWS [4] = '{
		'{2'h2, 2'h3, 2'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
		'{2'h0, 2'h2, 2'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0},
		'{2'h1, 2'h0, 2'h2, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1},
		'{2'h3, 2'h1, 2'h3, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0}};
	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic apb_psel_i = 1'h0, apb_penable_i = 1'h0, apb_pwrite_i = 1'h0, want = 1'h0;
	logic [11:0] apb_paddr_i = 12'h000;
	logic [31:0] apb_pwdata_i = 32'h0, apb_prdata_o, process_identifier_o, data_trace_address_o;
	// identification strap, value arbitrary
	logic [31:0] scan_id_code_i = 32'h5A3C_96E1;
	tpsi_core_t core_i = '0;
	logic apb_pready_o, apb_pslverr_o, trace_port_enable_i, data_more_early_seq_o, data_sequential_o;
	logic data_mem_request_o, data_write_flag_o, high_vector_select_o, instr_abort_flag_o, instr_request_n_o;
	logic instr_executed_o, fetch_sequential_o, compressed_state_flag_o, cop_late_cancel_o, core_stall_n_o;
	logic cop_pass_o, watchpoint_match_o, trace_big_endian_o, debug_state_ack_o, process_id_write_strobe_o;
	logic [1:0] cop_handshake_decode_o, cop_handshake_execute_o, data_transfer_size_o;
	logic [30:0] instr_fetch_address_o;
	logic [7:0] id_code_upper_byte_o, id_code_second_byte_o;
	int err_count = 0;
	int total_checks = 0;

	always #5 clk_i = ~clk_i;

	tpsi_trace_unit trc_u (.clk_i, .reset_i, .want_i(want), .trace_port_enable_o(trace_port_enable_i));
	tpsi_port dut_u (.clk_i, .reset_i, .apb_psel_i, .apb_penable_i, .apb_pwrite_i, .apb_paddr_i, .apb_pwdata_i,
		.apb_prdata_o, .apb_pready_o, .apb_pslverr_o, .core_i, .scan_id_code_i, .trace_port_enable_i,
		.cop_handshake_decode_o, .cop_handshake_execute_o, .data_trace_address_o, .data_transfer_size_o,
		.data_more_early_seq_o, .data_sequential_o, .data_mem_request_o, .data_write_flag_o, .high_vector_select_o,
		.instr_fetch_address_o, .instr_abort_flag_o, .id_code_upper_byte_o, .id_code_second_byte_o,
		.instr_request_n_o, .instr_executed_o, .fetch_sequential_o, .compressed_state_flag_o, .cop_late_cancel_o,
		.core_stall_n_o, .cop_pass_o, .watchpoint_match_o, .trace_big_endian_o, .debug_state_ack_o,
		.process_identifier_o, .process_id_write_strobe_o);

	task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		@(posedge clk_i);
		apb_psel_i <= 1'h1;
		apb_pwrite_i <= w;
		apb_paddr_i <= a;
		apb_pwdata_i <= d;
		@(posedge clk_i);
		apb_penable_i <= 1'h1;
		do @(posedge clk_i); while (apb_pready_o !== 1'h1);
		rd = apb_prdata_o;
		er = apb_pslverr_o;
		apb_psel_i <= 1'h0;
		apb_penable_i <= 1'h0;
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#50000;
		err_count++;
		$display("Error watchdog expected finish seen timeout");
		stop_test();
	end

	initial begin
		tpsi_row_t r;
		tpsi_core_t c;
		logic [31:0] rd;
		logic er, prev;
		repeat (6) @(posedge clk_i);
		#1;
		chk("reset hs", 2'h2, cop_handshake_decode_o);
		chk("reset stall", 1'h1, core_stall_n_o);
		chk("reset fetch req", 1'h1, instr_request_n_o);
		$display("test reset done");
		repeat (6) @(posedge clk_i);
		reset_i <= 1'h0;
		want <= 1'h1;
		repeat (3) @(posedge clk_i);
		prev = 1'h0;
		for (int i = 0; i < 4; i++) begin
			r = ROWS[i];
			c = '0;
			c.hs_decode = r.hd;
			c.hs_execute = r.he;
			c.dsize = r.sz;
			c.multi_xfer = r.multi;
			c.dreq = r.dreq;
			c.ifetch = r.fetch;
			c.stalled = r.stall;
			c.daddr = 32'hC000_0004 << i;
			c.iaddr = 32'h8000_0006 << i;
			c.dwrite = i[0];
			c.iabort = i[1];
			c.executed = ~i[0];
			c.iseq = i[1];
			c.compressed = i[0] ^ i[1];
			c.cop_pass = ~i[1];
			c.in_debug = i[0];
			@(posedge clk_i) core_i <= c;
			@(posedge clk_i) #1;
			chk("hs decode", r.hd, cop_handshake_decode_o);
			chk("hs execute", r.he, cop_handshake_execute_o);
			chk("size", r.sz, data_transfer_size_o);
			chk("data addr", c.daddr, data_trace_address_o);
			chk("early seq", r.early, data_more_early_seq_o);
			chk("data seq", prev, data_sequential_o);
			chk("data req", r.dreq, data_mem_request_o);
			chk("write flag", c.dwrite, data_write_flag_o);
			chk("fetch addr", c.iaddr[31:1], instr_fetch_address_o);
			chk("abort", c.iabort, instr_abort_flag_o);
			chk("fetch req", r.reqn, instr_request_n_o);
			chk("executed", c.executed, instr_executed_o);
			chk("fetch seq", c.iseq, fetch_sequential_o);
			chk("state", c.compressed, compressed_state_flag_o);
			chk("stall", r.stn, core_stall_n_o);
			chk("pass", c.cop_pass, cop_pass_o);
			chk("debug", c.in_debug, debug_state_ack_o);
			prev = r.early;
		end
		$display("test rows done");
		chk("id upper", 8'h5A, id_code_upper_byte_o);
		chk("id second", 8'h96, id_code_second_byte_o);
		apb(1'h0, 12'h00C, 32'h0, rd, er);
		chk("mask reset", 32'hFFFF_FFFF, rd);
		apb(1'h0, 12'h020, 32'h0, rd, er);
		chk("unmapped err", 1'h1, er);
		chk("unmapped data", 32'h0, rd);
		for (int v = 1; v < 3; v++) begin
			apb(1'h1, 12'h000, 32'(v), rd, er);
			repeat (3) @(posedge clk_i);
			#1;
			chk("big endian", v & 1, trace_big_endian_o);
			chk("high vectors", v >> 1, high_vector_select_o);
		end
		$display("test registers done");
		apb(1'h1, 12'h004, 32'hA5A5_0001, rd, er);
		#1;
		chk("id strobe early", 1'h0, process_id_write_strobe_o);
		@(posedge clk_i) #1;
		chk("id strobe", 1'h1, process_id_write_strobe_o);
		chk("id value", 32'hA5A5_0001, process_identifier_o);
		@(posedge clk_i) #1;
		chk("id strobe end", 1'h0, process_id_write_strobe_o);
		$display("test process id done");
		apb(1'h1, 12'h008, 32'h0000_2000, rd, er);
		apb(1'h1, 12'h00C, 32'h0, rd, er);
		for (int j = 0; j < 4; j++) begin
			if (j == 2) begin
				apb(1'h1, 12'h000, 32'h0000_000C, rd, er);
			end
			c = '0;
			c.dreq = 1'h1;
			c.dwrite = j[0];
			c.daddr = (j == 1) ? 32'h0000_2004 : 32'h0000_2000;
			@(posedge clk_i) core_i <= c;
			@(posedge clk_i) #1;
			chk("watch match", j == 0 || j == 3, watchpoint_match_o);
		end
		$display("test watchpoint done");
		for (int j = 0; j < 2; j++) begin
			c = '0;
			c.dreq = 1'h1;
			c.data_abort = j == 0;
			@(posedge clk_i) core_i <= c;
			c = '0;
			c.cop_first = 1'h1;
			@(posedge clk_i) core_i <= c;
			@(posedge clk_i) #1;
			chk("late cancel", j == 0, cop_late_cancel_o);
		end
		$display("test late cancel done");
		c = '0;
		c.dreq = 1'h1;
		@(posedge clk_i) core_i <= c;
		want <= 1'h0;
		repeat (3) @(posedge clk_i);
		#1;
		chk("off req", 1'h0, data_mem_request_o);
		chk("off hs", 2'h2, cop_handshake_decode_o);
		$display("test disable done");
		stop_test();
	end
endmodule

`default_nettype wire

//--- tpsi_procid.sv
/*
 * Process identifier holder with its one-cycle write strobe.
 * Assumes write requests come from the register bus on the same clock.
 */
`default_nettype none
`include "tpsi_cfg.svh"

module tpsi_procid import tpsi_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic wr_i,
	input wire logic [31:0] data_i,
	output logic [31:0] value_o,
	output logic strobe_o
);

	tpsi_procid_t s_d;
	tpsi_procid_t s_q;

	always_comb begin
		s_d = s_q;
		// value and strobe change on the same edge
		s_d.strobe = wr_i;
		if (wr_i) begin
			s_d.value = data_i;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_q.value <= `TPSI_PROCID_RST;
			s_q.strobe <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign value_o = s_q.value;
	assign strobe_o = s_q.strobe;

endmodule

`default_nettype wire

//--- tpsi_stage.sv
/*
 * One register stage for the whole trace bundle.
 * Assumes the enable comes from logic on the same clock.
 */
`default_nettype none

module tpsi_stage import tpsi_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire tpsi_trace_t trace_i,
	output tpsi_trace_t trace_o
);

	tpsi_trace_t s_d;
	tpsi_trace_t s_q;
	tpsi_trace_t idle;

	always_comb begin
		idle = '0;
		idle.cop_handshake_decode = `TPSI_HS_ABSENT;
		idle.cop_handshake_execute = `TPSI_HS_ABSENT;
		idle.instr_request_n = 1'b1;
		idle.core_stall_n = 1'b1;
		// disabled port rests at idle levels
		s_d = enable_i ? trace_i : idle;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_q <= '0;
			s_q.cop_handshake_decode <= `TPSI_HS_ABSENT;
			s_q.cop_handshake_execute <= `TPSI_HS_ABSENT;
			s_q.instr_request_n <= 1'b1;
			s_q.core_stall_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign trace_o = s_q;

endmodule

`default_nettype wire

//--- tpsi_trace_unit.sv
/*
 * trace unit model: drives the port enable as a registered level.
 * assumes the same clock and reset as the trace port.
 */
`default_nettype none

module tpsi_trace_unit (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic want_i,
	output logic trace_port_enable_o
);
	// enable only moves just after an edge
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			trace_port_enable_o <= 1'h0;
		end else begin
			trace_port_enable_o <= want_i;
		end
	end
endmodule

`default_nettype wire
